// ---- pkg/iseq_pkg.sv ----
`default_nettype none
package iseq_pkg;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_JUDGE_EN = 8'h10;
  localparam logic [7:0] REG_MAP_LO = 8'h14;
  localparam logic [7:0] REG_MAP_HI = 8'h18;
  localparam logic [7:0] REG_TOTAL_SEL = 8'h1C;
  localparam logic [7:0] REG_RESULT = 8'h20;
  // Interrupt event bit positions
  localparam int EV_CAP = 0;
  localparam int EV_CYCLE = 1;
  localparam int EV_IGN = 2;
  localparam int EV_W = 3;
  // Judgment packing
  localparam int JUDGE_N = 16;
  localparam int POS_W = 4;
  // Reset values
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [JUDGE_N-1:0] JUDGE_EN_RST = 16'h0000;
  localparam logic [POS_W-1:0] TOTAL_SEL_RST = 4'h0;
  // Least request width: 1 ms, rounded up to cycles
  localparam int CLK_PERIOD_NS = 100;
  localparam int REQ_MIN_NS = 1000000;
  localparam int REQ_WIDTH_CYC = (REQ_MIN_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // Trigger modes
  typedef enum logic [1:0] {
    MODE_CAM1,
    MODE_CAM2,
    MODE_DUAL,
    MODE_SHARED
  } iseq_mode_t;
  localparam iseq_mode_t MODE_RST = MODE_CAM1;
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAPTURE,
    ST_WAIT,
    ST_PROCESS
  } iseq_state_t;
  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } iseq_bus_t;
endpackage
`default_nettype wire

// ---- core/iseq_sequencer.sv ----
// Summary of operation
// - Accepted request drops capture done
// - Capture done returns after capture finishes
// - Ready drops on request, rises after processing
// - Single camera: camera follows own line
// - Dual mode: each camera own done
// - Second capture deferred until first completes
// - Dual mode accepts requests either order
// - Dual mode waits both captures before processing
// - Shared mode: line one captures both cameras
// - Shared mode: done after both images
// - Pack 16 judgments at chosen bit positions
// - Total output follows chosen overall judgment
// - Judgment OK is 1, NG is 0
// - Requests ignored while capture done low
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module iseq_sequencer #(
  parameter int unsigned REQ_WIDTH_CYC = iseq_pkg::REQ_WIDTH_CYC
) (
  input wire logic sys_clk, // 10 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire iseq_pkg::iseq_bus_t bus, // Register request
  output logic [31:0] rd_data, // Read data, cycle after read
  output logic irq, // Level interrupt
  input wire logic capture_request_1, // Request pin one
  input wire logic capture_request_2, // Request pin two
  output logic capture_done_1, // Camera one capture done
  output logic capture_done_2, // Camera two capture done
  output logic ready, // Inspection ready
  output logic cam_start_1, // Start pulse to camera one
  output logic cam_start_2, // Start pulse to camera two
  input wire logic [1:0] cam_done_in, // Camera capture finished
  output logic proc_start, // Start pulse to processing
  input wire logic proc_done_in, // Processing finished
  input wire logic [15:0] judge_in, // Judgments, OK=1 NG=0
  output logic [15:0] judge_word, // Packed judgment word
  output logic total_result_out // Overall judgment pin
);
  import iseq_pkg::*;
  localparam logic [CNT_W-1:0] CNT_LIM = CNT_W'(REQ_WIDTH_CYC);
  iseq_state_t state;
  iseq_mode_t mode;
  logic cur;
  logic oth;
  logic [1:0] got;
  logic [1:0] pend;
  logic [1:0] cap_done;
  logic [1:0] cam_go;
  logic [1:0] qreq;
  logic [1:0] acc;
  logic [1:0] allow;
  logic open_win;
  logic [EV_W-1:0] irq_stat;
  logic [EV_W-1:0] irq_mask;
  logic [EV_W-1:0] ev;
  logic [JUDGE_N-1:0] judge_en;
  logic [31:0] map_lo;
  logic [31:0] map_hi;
  logic [POS_W-1:0] total_sel;
  logic [JUDGE_N-1:0] packed_word;
  logic [JUDGE_N-1:0] contrib [JUDGE_N];
  logic [2*32-1:0] map_all;
  logic [1:0] req_pin;
  assign req_pin = {capture_request_2, capture_request_1};
  assign oth = ~cur;
  assign capture_done_1 = cap_done[0];
  assign capture_done_2 = cap_done[1];
  assign cam_start_1 = cam_go[0];
  assign cam_start_2 = cam_go[1];
  assign map_all = {map_hi, map_lo};
  // Two-flop sync and width qualifier per request line
  generate
    for (genvar j = 0; j < 2; j++) begin : g_req
      logic s1;
      logic s2;
      logic [CNT_W-1:0] cnt;
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          cnt <= '0;
        end else if (ce) begin
          s1 <= req_pin[j];
          s2 <= s1;
          if (!s2) begin
            cnt <= '0;
          end else if (cnt != CNT_LIM) begin
            cnt <= cnt + 1'b1;
          end
        end
      end
      // One pulse once the level has held long enough
      assign qreq[j] = s2 && (cnt == CNT_LIM - 1'b1);
    end
  endgenerate
  // Which lines may be accepted now
  always_comb begin
    allow[0] = (mode != MODE_CAM2);
    allow[1] = (mode == MODE_CAM2) || (mode == MODE_DUAL);
    open_win = (state == ST_IDLE) ||
               ((mode == MODE_DUAL) && (state != ST_PROCESS));
    // Capture done low blocks its line
    acc = qreq & allow & cap_done & ~got & ~pend &
          {2{open_win}};
  end
  // Trigger sequencer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cur <= 1'b0;
      got <= 2'b00;
      pend <= 2'b00;
      cap_done <= 2'b11;
      ready <= 1'b1;
      cam_go <= 2'b00;
      proc_start <= 1'b0;
    end else if (ce) begin
      cam_go <= 2'b00;
      proc_start <= 1'b0;
      if (acc != 2'b00) begin
        ready <= 1'b0;
      end
      if (acc[0]) begin
        cap_done[0] <= 1'b0;
      end
      if (acc[1]) begin
        cap_done[1] <= 1'b0;
      end
      case (state)
        ST_IDLE, ST_WAIT: begin
          if (acc[0]) begin
            cam_go[0] <= 1'b1;
            cur <= 1'b0;
            pend[1] <= acc[1];
            state <= ST_CAPTURE;
          end else if (acc[1]) begin
            cam_go[1] <= 1'b1;
            cur <= 1'b1;
            state <= ST_CAPTURE;
          end
        end
        ST_CAPTURE: begin
          if (acc[oth]) begin
            pend[oth] <= 1'b1;
          end
          if (cam_done_in[cur]) begin
            if (mode == MODE_SHARED && !cur) begin
              cam_go[1] <= 1'b1;
              cur <= 1'b1;
            end else if (mode == MODE_SHARED) begin
              cap_done[0] <= 1'b1;
              proc_start <= 1'b1;
              state <= ST_PROCESS;
            end else begin
              cap_done[cur] <= 1'b1;
              got[cur] <= 1'b1;
              if (mode != MODE_DUAL || got[oth]) begin
                proc_start <= 1'b1;
                state <= ST_PROCESS;
              end else if (pend[oth] || acc[oth]) begin
                cam_go[oth] <= 1'b1;
                cur <= oth;
                pend[oth] <= 1'b0;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
        end
        ST_PROCESS: begin
          if (proc_done_in) begin
            ready <= 1'b1;
            got <= 2'b00;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
  // Place each enabled judgment at its chosen bit
  generate
    for (genvar j = 0; j < JUDGE_N; j++) begin : g_pack
      assign contrib[j] = (judge_en[j] && judge_in[j]) ?
        (16'h0001 << map_all[j*POS_W +: POS_W]) : 16'h0000;
    end
  endgenerate
  // Merge the placed judgments
  always_comb begin
    packed_word = 16'h0000;
    for (int i = 0; i < JUDGE_N; i++) begin
      packed_word = packed_word | contrib[i];
    end
  end
  // Latch results when processing ends
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      judge_word <= 16'h0000;
      total_result_out <= 1'b0;
    end else if (ce && state == ST_PROCESS && proc_done_in) begin
      judge_word <= packed_word;
      total_result_out <= packed_word[total_sel];
    end
  end
  // Interrupt events
  always_comb begin
    ev = '0;
    ev[EV_CAP] = (state == ST_CAPTURE) && cam_done_in[cur];
    ev[EV_CYCLE] = (state == ST_PROCESS) && proc_done_in;
    ev[EV_IGN] = |(qreq & ~acc);
  end
  // Sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      if (bus.wr && bus.addr == REG_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~bus.wdata[EV_W-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end
  // Software-written registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= MODE_RST;
      irq_mask <= IRQ_MASK_RST;
      judge_en <= JUDGE_EN_RST;
      map_lo <= 32'h0000_0000;
      map_hi <= 32'h0000_0000;
      total_sel <= TOTAL_SEL_RST;
    end else if (ce && bus.wr) begin
      if (bus.addr == REG_CTRL) begin
        mode <= iseq_mode_t'(bus.wdata[1:0]);
      end else if (bus.addr == REG_IRQ_MASK) begin
        irq_mask <= bus.wdata[EV_W-1:0];
      end else if (bus.addr == REG_JUDGE_EN) begin
        judge_en <= bus.wdata[JUDGE_N-1:0];
      end else if (bus.addr == REG_MAP_LO) begin
        map_lo <= bus.wdata;
      end else if (bus.addr == REG_MAP_HI) begin
        map_hi <= bus.wdata;
      end else if (bus.addr == REG_TOTAL_SEL) begin
        total_sel <= bus.wdata[POS_W-1:0];
      end
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 32'h0000_0000;
    end else if (ce) begin
      if (!bus.rd) begin
        rd_data <= 32'h0000_0000;
      end else if (bus.addr == REG_CTRL) begin
        rd_data <= {30'h0, mode};
      end else if (bus.addr == REG_STATE) begin
        rd_data <= {27'h0, state, cap_done, ready};
      end else if (bus.addr == REG_IRQ_STAT) begin
        rd_data <= {29'h0, irq_stat};
      end else if (bus.addr == REG_IRQ_MASK) begin
        rd_data <= {29'h0, irq_mask};
      end else if (bus.addr == REG_JUDGE_EN) begin
        rd_data <= {16'h0, judge_en};
      end else if (bus.addr == REG_MAP_LO) begin
        rd_data <= map_lo;
      end else if (bus.addr == REG_MAP_HI) begin
        rd_data <= map_hi;
      end else if (bus.addr == REG_TOTAL_SEL) begin
        rd_data <= {28'h0, total_sel};
      end else if (bus.addr == REG_RESULT) begin
        rd_data <= {15'h0, total_result_out, judge_word};
      end else begin
        rd_data <= 32'h0000_0000;
      end
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_REQ_QUALIFY: assert property (
    ce && qreq[0] |=> !qreq[0] && g_req[0].cnt == CNT_LIM)
    else $error("request qualifier fired twice");
  AST_ACCEPT_DROPS_DONE: assert property (
    ce && acc[0] |=> !capture_done_1 && !ready)
    else $error("accept left capture done high");
  AST_DONE_ON_CAPTURE: assert property (
    ce && state == ST_CAPTURE && !cur && cam_done_in[0] &&
    mode != MODE_SHARED |=> capture_done_1)
    else $error("capture done not restored");
  AST_READY_AFTER_PROC: assert property (
    $rose(ready) |-> $past(proc_done_in) && $past(state) == ST_PROCESS)
    else $error("ready rose without processing end");
  AST_SINGLE_LINE: assert property (
    (mode != MODE_CAM1 || !cam_start_2) &&
    (mode != MODE_CAM2 || !cam_start_1))
    else $error("camera started by the wrong request line");
  AST_DEFER_SECOND: assert property (
    cam_go[1] && mode == MODE_DUAL |->
    $past(state) != ST_CAPTURE || $past(cam_done_in[0]))
    else $error("second capture overlapped first");
  AST_PROC_AFTER_BOTH: assert property (
    proc_start && mode == MODE_DUAL |-> cap_done == 2'b11 && got == 2'b11)
    else $error("processing began before both captures");
  AST_SHARED_CHAIN: assert property (
    ce && mode == MODE_SHARED && state == ST_CAPTURE && !cur &&
    cam_done_in[0] |=> cam_start_2 && !capture_done_1)
    else $error("shared mode did not chain camera two");
  AST_SHARED_DONE: assert property (
    mode == MODE_SHARED && $rose(capture_done_1) |->
    $past(cur) && $past(cam_done_in[1]))
    else $error("shared done before second image");
  AST_TOTAL_PIN: assert property (
    ce && state == ST_PROCESS && proc_done_in |=>
    total_result_out == judge_word[total_sel])
    else $error("total result mismatches packed word");
  AST_IGNORE_BUSY: assert property (
    ce && !capture_done_1 && qreq[0] |=> irq_stat[EV_IGN])
    else $error("busy request not flagged as ignored");

  COV_SINGLE: cover property (mode == MODE_CAM1 && $rose(ready));
  COV_DUAL_DEFER: cover property (mode == MODE_DUAL && pend != 2'b00);
  COV_DUAL_WAIT: cover property (mode == MODE_DUAL && state == ST_WAIT);
  COV_SHARED: cover property (mode == MODE_SHARED && proc_start);
endmodule
`default_nettype wire

// ---- dv/iseq_cam_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iseq_cam_model #(
  parameter int DLY = 20
) (
  input wire logic sys_clk, // Clock
  input wire logic resetn, // Reset, active low
  input wire logic cam_start_1, // Camera one start
  input wire logic cam_start_2, // Camera two start
  input wire logic proc_start, // Processing start
  output logic [1:0] cam_done_in, // Capture finished pulses
  output logic proc_done_in // Processing finished pulse
);
  int c1, c2, cp;
  // Each start arms a countdown; the finish pulse comes at its end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      c1 <= 0;
      c2 <= 0;
      cp <= 0;
      cam_done_in <= 2'h0;
      proc_done_in <= 1'b0;
    end else begin
      c1 <= cam_start_1 ? DLY : (c1 > 0 ? c1 - 1 : 0);
      c2 <= cam_start_2 ? DLY : (c2 > 0 ? c2 - 1 : 0);
      cp <= proc_start ? DLY : (cp > 0 ? cp - 1 : 0);
      cam_done_in <= {c2 == 1, c1 == 1};
      proc_done_in <= (cp == 1);
    end
  end
endmodule
`default_nettype wire

// ---- dv/iseq_sequencer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module iseq_sequencer_tb;
  import iseq_pkg::*;
  localparam int RW = 4;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  iseq_bus_t bus = '0;
  logic [31:0] rd_data, rv;
  logic irq, ready, capture_done_1, capture_done_2, proc_start, proc_done_in;
  logic capture_request_1 = 1'b0;
  logic capture_request_2 = 1'b0;
  logic cam_start_1, cam_start_2, total_result_out;
  logic [1:0] cam_done_in;
  logic [15:0] judge_in = 16'h0000;
  logic [15:0] judge_word;
  int err_total = 0;
  int n_checks = 0;
  int ns1 = 0, ns2 = 0, cyc = 0, t_d0 = 0, t_s2 = 0;

  iseq_sequencer #(.REQ_WIDTH_CYC(RW)) iseq_sequencer_inst (.sys_clk,
    .resetn, .ce, .bus, .rd_data, .irq, .capture_request_1,
    .capture_request_2, .capture_done_1, .capture_done_2, .ready,
    .cam_start_1, .cam_start_2, .cam_done_in, .proc_start, .proc_done_in,
    .judge_in, .judge_word, .total_result_out);
  iseq_cam_model iseq_cam_model_inst (.sys_clk, .resetn, .cam_start_1,
    .cam_start_2, .proc_start, .cam_done_in, .proc_done_in);

  // Clock
  always #50 sys_clk = ~sys_clk;
  // Counts of start pulses, moment of camera two start and of camera one done
  always @(posedge sys_clk) begin
    cyc++;
    if (cam_start_1 === 1'b1) ns1++;
    if (cam_start_2 === 1'b1) begin
      ns2++;
      t_s2 = cyc;
    end
    if (cam_done_in[0] === 1'b1) t_d0 = cyc;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1 d = rd_data;
  endtask
  // Pulse one request line, wide enough to qualify
  task automatic req(input int n);
    @(posedge sys_clk);
    if (n == 1) capture_request_1 <= 1'b1;
    else capture_request_2 <= 1'b1;
    repeat (RW + 4) @(posedge sys_clk);
    capture_request_1 <= 1'b0;
    capture_request_2 <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait for ready (0) or a capture done (1, 2) to be high
  task automatic wt(input int s);
    logic v;
    for (int i = 0; i < 400; i++) begin
      v = (s == 0) ? ready : (s == 1) ? capture_done_1 : capture_done_2;
      if (v === 1'b1) return;
      @(posedge sys_clk);
      #1;
    end
    chk(32'h0, 32'h1);
  endtask

  task automatic t_reset;
    rd(REG_STATE, rv);
    chk(rv, 32'h7);
    rd(8'h3C, rv);
    chk(rv, 32'h0);
  endtask
  task automatic t_single;
    int b;
    b = ns1;
    wr(REG_CTRL, 32'h0);
    req(1);
    chk({capture_done_1, ready}, 2'h0);
    req(1);
    wt(1);
    chk(ready, 1'b0);
    wt(0);
    chk(ns1 - b, 32'h1);
    rd(REG_IRQ_STAT, rv);
    chk(rv, 32'h7);
  endtask
  task automatic t_cam2;
    wr(REG_IRQ_STAT, 32'h7);
    req(2);
    chk({capture_done_2, ready}, 2'h3);
    rd(REG_IRQ_STAT, rv);
    chk(rv, 32'h4);
    wr(REG_CTRL, 32'h1);
    req(1);
    chk({capture_done_1, ready}, 2'h3);
    req(2);
    chk({capture_done_2, capture_done_1}, 2'h1);
    wt(0);
  endtask
  task automatic t_dual;
    wr(REG_CTRL, 32'h2);
    req(2);
    wt(2);
    repeat (30) @(posedge sys_clk);
    #1 chk(ready, 1'b0);
    req(1);
    wt(0);
    chk({capture_done_1, capture_done_2, ready}, 3'h7);
    req(1);
    req(2);
    wt(0);
    chk(t_s2 - t_d0, 32'h1);
  endtask
  task automatic t_judge;
    wr(REG_JUDGE_EN, 32'h5);
    wr(REG_MAP_LO, 32'h00000C0F);
    wr(REG_TOTAL_SEL, 32'hF);
    wr(REG_CTRL, 32'h0);
    judge_in <= 16'h0001;
    req(1);
    wt(0);
    chk(judge_word, 16'h8000);
    chk(total_result_out, 1'b1);
    rd(REG_RESULT, rv);
    chk(rv, 32'h00018000);
    @(posedge sys_clk);
    judge_in <= 16'h0004;
    req(1);
    wt(0);
    chk({total_result_out, judge_word}, 17'h01000);
  endtask
  task automatic t_shared;
    int b;
    b = ns2;
    wr(REG_CTRL, 32'h3);
    req(1);
    repeat (25) @(posedge sys_clk);
    #1 chk(capture_done_1, 1'b0);
    chk(ns2 - b, 32'h1);
    wt(0);
    chk(capture_done_1, 1'b1);
  endtask
  task automatic t_irq;
    wr(REG_IRQ_MASK, 32'h4);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b1);
    wr(REG_IRQ_STAT, 32'h7);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b0);
  endtask
  // Frozen write is lost; a short request pulse never qualifies
  task automatic t_freeze;
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(REG_TOTAL_SEL, 32'h3);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(REG_TOTAL_SEL, rv);
    chk(rv, 32'hF);
    @(posedge sys_clk);
    capture_request_1 <= 1'b1;
    repeat (2) @(posedge sys_clk);
    capture_request_1 <= 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 chk({capture_done_1, ready}, 2'h3);
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_single;
    t_cam2;
    t_dual;
    t_judge;
    t_shared;
    t_irq;
    t_freeze;
    end_of_test;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
